// ==== rtl/asq_pkg.sv ====
package asq_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] ASQ_OFF_INPUT_SEL = 12'h040;
    localparam logic [11:0] ASQ_OFF_STEP_CTL  = 12'h044;
    localparam logic [11:0] ASQ_OFF_RIS       = 12'h000;
    localparam logic [11:0] ASQ_OFF_IM        = 12'h008;
    localparam logic [11:0] ASQ_OFF_ISC       = 12'h00c;
    localparam logic [11:0] ASQ_OFF_TRIG      = 12'h014;
    localparam logic [11:0] ASQ_OFF_STAT      = 12'h018;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int          ASQ_STEPS       = 8;
    localparam int          ASQ_SEL_W       = 2;
    localparam int          ASQ_SEL_STRIDE  = 4;
    localparam int          ASQ_GRP_W       = 4;
    localparam int          ASQ_BIT_DIFF    = 0;
    localparam int          ASQ_BIT_LAST    = 1;
    localparam int          ASQ_BIT_IRQ     = 2;
    localparam int          ASQ_BIT_TEMP    = 3;
    localparam logic [31:0] ASQ_SEL_WMASK   = 32'h0000_0333;
    localparam logic [31:0] ASQ_CTL_RESET   = 32'h0000_0000;
    localparam logic [31:0] ASQ_SEL_RESET   = 32'h0000_0000;
    localparam int          ASQ_STEP_W      = 3;
    localparam logic [2:0]  ASQ_STEP_FIRST  = 3'h0;
    localparam logic [2:0]  ASQ_STEP_TOP    = 3'h7;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        ASQ_IDLE = 3'b001,
        ASQ_REQ  = 3'b010,
        ASQ_WAIT = 3'b100
    } asq_state_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] step;
        logic       temp;
        logic       diff;
        logic [1:0] sel;
        logic [3:0] pos_pin;
        logic [3:0] neg_pin;
    } asq_conv_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } asq_apb_req_t;

endpackage

// ==== rtl/asq_seq0.sv ====
// Behaviour
// - Third step converts input chosen by select bits 9:8.
// - Second step converts input chosen by select bits 5:4.
// - First step converts input chosen by select bits 1:0.
// - Temperature flag set samples the sensor, else the selected pin.
// - Interrupt flag set raises raw interrupt when that step completes.
// - Raw interrupt reaches the controller only when its mask bit is set.
// - Any number of steps may raise the raw interrupt.
// - A step with its last flag set ends the sequence.
// - Steps after the first last flag are never requested.
// - Single-step sequencer 3 has its last flag fixed set.
// - Differential flag set samples an input pair.
// - Differential select value i picks inputs 2i and 2i+1.
// - Control word: four-bit groups temp, irq, last, diff, high to low.
// - Reserved select bits read as zero; software preserves them.
// - Single-ended select value n means input pin n.
`timescale 1ns/10ps
module asq_seq0
    import asq_pkg::*;
#(
    parameter int STEPS = ASQ_STEPS
)
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    // APB slave
    input  wire asq_pkg::asq_apb_req_t apb_req,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // Converter core
    input  wire logic                conv_done,
    output asq_pkg::asq_conv_t       conv_req,
    // Interrupt
    output logic                     irq
);
    import asq_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic ctl_bit(input logic [31:0] w, input logic [2:0] s, input int b);
        ctl_bit = w[int'(s) * ASQ_GRP_W + b];
    endfunction

    function automatic logic [1:0] sel_of(input logic [31:0] w, input logic [2:0] s);
        sel_of = w[int'(s) * ASQ_SEL_STRIDE +: ASQ_SEL_W];
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            ASQ_OFF_STEP_CTL, ASQ_OFF_INPUT_SEL, ASQ_OFF_RIS, ASQ_OFF_IM,
            ASQ_OFF_ISC, ASQ_OFF_TRIG, ASQ_OFF_STAT: is_mapped = 1'b1;
            default:                                 is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [3:0] pos_pin_of(input logic [1:0] s, input logic d);
        if (d)
            pos_pin_of = {1'b0, s, 1'b0};
        else
            pos_pin_of = {2'h0, s};
    endfunction

    function automatic logic [3:0] neg_pin_of(input logic [1:0] s, input logic d);
        if (d)
            neg_pin_of = {1'b0, s, 1'b1};
        else
            neg_pin_of = 4'h0;
    endfunction

    // ************************************************************
    // Fixed last flag of a single-step sequencer
    // ************************************************************
    localparam logic [31:0] LAST_FIXED = (STEPS == 1) ? (32'h1 << ASQ_BIT_LAST) : 32'h0;

    logic [31:0]  ctl_q;
    logic [31:0]  sel_q;
    logic         ris_q;
    logic         im_q;
    logic         trig_q;
    asq_state_t   state_q;
    logic [2:0]   step_q;
    asq_conv_t    conv_q;
    logic         irq_q;
    logic         pready_q;
    logic [31:0]  prdata_q;
    logic         perr_q;
    logic         done_s1_q;
    logic         done_s2_q;
    logic         done_prev_q;
    logic         done_pulse;
    logic         step_irq;
    logic         wr;
    logic         rd;
    logic [1:0]   cur_sel;
    logic         cur_diff;
    logic         acc;
    logic         wr_ctl;
    logic         wr_sel;
    logic         wr_im;
    logic         wr_isc;
    logic         wr_trig;
    logic [1:0]   step0_input_sel;
    logic [1:0]   step1_input_sel;
    logic [1:0]   step2_input_sel;

    assign done_pulse = done_s2_q & ~done_prev_q;
    assign acc        = apb_req.psel & apb_req.penable & ~pready_q;
    assign rd         = acc & ~apb_req.pwrite;
    assign wr         = apb_req.psel & apb_req.penable & apb_req.pwrite & pready_q;
    assign step_irq   = (state_q == ASQ_WAIT) & done_pulse
                        & ctl_bit(ctl_q, step_q, ASQ_BIT_IRQ);
    assign cur_diff   = ctl_bit(ctl_q, step_q, ASQ_BIT_DIFF);

    // ************************************************************
    // Step input-select views
    // ************************************************************
    assign step0_input_sel = sel_of(sel_q, ASQ_STEP_FIRST);
    assign step1_input_sel = sel_of(sel_q, ASQ_STEP_FIRST + 3'h1);
    assign step2_input_sel = sel_of(sel_q, ASQ_STEP_FIRST + 3'h2);

    always_comb
    begin
        case (step_q)
            ASQ_STEP_FIRST:        cur_sel = step0_input_sel;
            ASQ_STEP_FIRST + 3'h1: cur_sel = step1_input_sel;
            ASQ_STEP_FIRST + 3'h2: cur_sel = step2_input_sel;
            default:               cur_sel = 2'h0;
        endcase
    end

    // ************************************************************
    // Write commit decode
    // ************************************************************
    assign wr_ctl  = wr & (apb_req.paddr == ASQ_OFF_STEP_CTL);
    assign wr_sel  = wr & (apb_req.paddr == ASQ_OFF_INPUT_SEL);
    assign wr_im   = wr & (apb_req.paddr == ASQ_OFF_IM);
    assign wr_isc  = wr & (apb_req.paddr == ASQ_OFF_ISC) & apb_req.pwdata[0];
    assign wr_trig = wr & (apb_req.paddr == ASQ_OFF_TRIG) & apb_req.pwdata[0];

    // ************************************************************
    // Completion input synchroniser
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_s1_q   <= 1'b0;
            done_s2_q   <= 1'b0;
            done_prev_q <= 1'b0;
        end
        else if (clk_en)
        begin
            done_s1_q   <= conv_done;
            done_s2_q   <= done_s1_q;
            done_prev_q <= done_s2_q;
        end
    end

    // ************************************************************
    // APB ready
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_q <= 1'b0;
        end
        else if (clk_en)
        begin
            pready_q <= acc;
        end
    end

    // ************************************************************
    // APB error response
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            perr_q <= 1'b0;
        end
        else if (clk_en)
        begin
            perr_q <= acc & ~is_mapped(apb_req.paddr);
        end
    end

    // ************************************************************
    // APB read data
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata_q <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            prdata_q <= 32'h0000_0000;
            if (rd)
            begin
                case (apb_req.paddr)
                    ASQ_OFF_STEP_CTL:  prdata_q <= ctl_q;
                    ASQ_OFF_INPUT_SEL: prdata_q <= sel_q & ASQ_SEL_WMASK;
                    ASQ_OFF_RIS:       prdata_q <= {31'h0, ris_q};
                    ASQ_OFF_IM:        prdata_q <= {31'h0, im_q};
                    ASQ_OFF_STAT:      prdata_q <= {28'h0, state_q != ASQ_IDLE, step_q};
                    ASQ_OFF_ISC, ASQ_OFF_TRIG: prdata_q <= 32'h0000_0000;
                    default:           prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // Step control word
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_q <= ASQ_CTL_RESET | LAST_FIXED;
        end
        else if (clk_en && wr_ctl)
        begin
            ctl_q <= apb_req.pwdata | LAST_FIXED;
        end
    end

    // ************************************************************
    // Input select word
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_q <= ASQ_SEL_RESET;
        end
        else if (clk_en && wr_sel)
        begin
            sel_q <= apb_req.pwdata & ASQ_SEL_WMASK;
        end
    end

    // ************************************************************
    // Interrupt mask
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            im_q <= 1'b0;
        end
        else if (clk_en && wr_im)
        begin
            im_q <= apb_req.pwdata[0];
        end
    end

    // ************************************************************
    // Trigger
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_q <= 1'b0;
        end
        else if (clk_en)
        begin
            trig_q <= wr_trig;
        end
    end

    // ************************************************************
    // Raw interrupt status
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ris_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (step_irq)
                ris_q <= 1'b1;
            else if (wr_isc)
                ris_q <= 1'b0;
        end
    end

    // ************************************************************
    // Interrupt output
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_q <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_q <= (ris_q | step_irq) & im_q;
        end
    end

    // ************************************************************
    // Step sequencer
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ASQ_IDLE;
            step_q  <= ASQ_STEP_FIRST;
        end
        else if (clk_en)
        begin
            case (state_q)
                ASQ_IDLE:
                begin
                    if (trig_q)
                    begin
                        step_q  <= ASQ_STEP_FIRST;
                        state_q <= ASQ_REQ;
                    end
                end
                ASQ_REQ:
                    state_q <= ASQ_WAIT;
                ASQ_WAIT:
                begin
                    if (done_pulse)
                    begin
                        if (ctl_bit(ctl_q, step_q, ASQ_BIT_LAST)
                            || step_q == 3'(STEPS - 1))
                            state_q <= ASQ_IDLE;
                        else
                        begin
                            step_q  <= step_q + 3'h1;
                            state_q <= ASQ_REQ;
                        end
                    end
                end
                default:
                    state_q <= ASQ_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Converter front-end steering
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            conv_q <= '0;
        else if (clk_en)
        begin
            conv_q.valid <= (state_q == ASQ_REQ);
            if (state_q == ASQ_REQ)
            begin
                conv_q.step    <= step_q;
                conv_q.temp    <= ctl_bit(ctl_q, step_q, ASQ_BIT_TEMP);
                conv_q.diff    <= cur_diff;
                conv_q.sel     <= cur_sel;
                conv_q.pos_pin <= pos_pin_of(cur_sel, cur_diff);
                conv_q.neg_pin <= neg_pin_of(cur_sel, cur_diff);
            end
        end
    end

    assign pready   = pready_q;
    assign prdata   = prdata_q;
    assign pslverr  = perr_q;
    assign conv_req = conv_q;
    assign irq      = irq_q;

endmodule

// ==== test/asq_conv_model.sv ====
`timescale 1ns/10ps
module asq_conv_model
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Converter side
    input  wire asq_pkg::asq_conv_t conv_req,
    input  wire logic               slow,
    output logic                    conv_done
);
    import asq_pkg::*;
    // ****************************************
    // Conversion answer, prompt or slow
    // ****************************************
    asq_conv_t log_q[$];
    int        wait_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_done <= 1'b0;
            wait_q    <= 0;
        end
        else if (conv_req.valid)
        begin
            log_q.push_back(conv_req);
            wait_q <= slow ? 9 : 3;
        end
        else if (wait_q != 0)
        begin
            wait_q    <= wait_q - 1;
            conv_done <= (wait_q <= 2);
        end
        else
            conv_done <= 1'b0;
    end
endmodule

// ==== test/asq_seq0_sva.sv ====
`timescale 1ns/10ps
module asq_seq0_sva
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  clk_en,
    // Bus side
    input wire asq_pkg::asq_apb_req_t apb_req,
    input wire logic                  pready,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    // Core side
    input wire asq_pkg::asq_conv_t    conv_req
);
    import asq_pkg::*;
    logic [2:0] last_q;
    logic       mapped;
    assign mapped = apb_req.paddr inside {ASQ_OFF_INPUT_SEL, ASQ_OFF_STEP_CTL,
        ASQ_OFF_RIS, ASQ_OFF_IM, ASQ_OFF_ISC, ASQ_OFF_TRIG, ASQ_OFF_STAT};
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            last_q <= 3'h0;
        else if (conv_req.valid)
            last_q <= conv_req.step;
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_taken; apb_req.psel && apb_req.penable && !pready && clk_en; endsequence
    sequence s_answer; ##1 pready ##1 !pready; endsequence
    property p_apb; s_taken |-> s_answer; endproperty
    a_apb: assert property (p_apb) else $error("ready not one pulse after access");
    property p_err; pready |-> pslverr == !mapped; endproperty
    a_err: assert property (p_err) else $error("error flag wrong for address");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside ready");
    property p_pulse; conv_req.valid |=> !conv_req.valid; endproperty
    a_pulse: assert property (p_pulse) else $error("request longer than a cycle");
    property p_hold; !conv_req.valid |=> conv_req.valid || $stable(conv_req); endproperty
    a_hold: assert property (p_hold) else $error("request fields moved");
    property p_order; conv_req.valid && conv_req.step != 3'h0 |->
        conv_req.step == last_q + 3'h1; endproperty
    a_order: assert property (p_order) else $error("step out of order");
    property p_diff; conv_req.valid && conv_req.diff |-> conv_req.pos_pin ==
        {1'b0, conv_req.sel, 1'b0} && conv_req.neg_pin == {1'b0, conv_req.sel, 1'b1};
    endproperty
    a_diff: assert property (p_diff) else $error("pair pins wrong");
    property p_single; conv_req.valid && !conv_req.diff && !conv_req.temp |->
        conv_req.pos_pin == {2'b00, conv_req.sel}; endproperty
    a_single: assert property (p_single) else $error("single pin wrong");
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import asq_pkg::*;
    logic         clk;
    logic         rst_n;
    logic         slow;
    logic         clk_en;
    logic         done;
    logic         pready;
    logic         pslverr;
    logic         irq;
    logic         err;
    logic [31:0]  prdata;
    logic [31:0]  rd;
    int           fail_count;
    int           compares;
    int           b;
    asq_apb_req_t apb_req;
    asq_conv_t    conv_req;
    logic [15:0]  exp_t [3] = '{16'h8110, 16'h9645, 16'hab00};
    logic [15:0]  msk_t [3] = '{16'hffff, 16'hffff, 16'hff00};
    // ****************************************
    // Design, core model and clock
    // ****************************************
    asq_seq0 u_asq_seq0
    (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .apb_req(apb_req), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .conv_done(done), .conv_req(conv_req), .irq(irq)
    );
    asq_conv_model u_asq_conv_model
    (
        .clk(clk), .rst_n(rst_n), .conv_req(conv_req), .slow(slow), .conv_done(done)
    );
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!pready && n < 20);
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
        if (!pready)
        begin
            fail_count++;
            end_sim();
        end
    endtask
    task automatic run_seq(input logic [31:0] ctl, input logic im, input int n, input logic ris);
        int k;
        int b0;
        b0 = u_asq_conv_model.log_q.size();
        apb(1'b1, ASQ_OFF_STEP_CTL, ctl);
        apb(1'b1, ASQ_OFF_IM, {31'h0, im});
        apb(1'b1, ASQ_OFF_TRIG, 32'h1);
        k = 0;
        do
        begin
            apb(1'b0, ASQ_OFF_STAT, 32'h0);
            k++;
        end
        while (rd[3] && k < 100);
        if (rd[3])
            fail_count++;
        check(u_asq_conv_model.log_q.size() - b0, n);
        apb(1'b0, ASQ_OFF_RIS, 32'h0);
        check(rd, {31'h0, ris});
        check({31'h0, irq}, {31'h0, ris & im});
        apb(1'b1, ASQ_OFF_ISC, 32'h1);
        apb(1'b0, ASQ_OFF_RIS, 32'h0);
        check({31'h0, rd[0], irq}, 32'h0);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rst_n = 1'b0;
        slow = 1'b0;
        clk_en = 1'b1;
        apb_req = '0;
        fail_count = 0;
        compares = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, ASQ_OFF_STEP_CTL, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, ASQ_OFF_INPUT_SEL, 32'hffff_ffff);
        apb(1'b0, ASQ_OFF_INPUT_SEL, 32'h0);
        check(rd, 32'h0000_0333);
        apb(1'b1, ASQ_OFF_STEP_CTL, 32'ha5a5_5a5a);
        apb(1'b0, ASQ_OFF_STEP_CTL, 32'h0);
        check(rd, 32'ha5a5_5a5a);
        apb(1'b0, 12'h0fc, 32'h0);
        check({31'h0, err}, 32'h1);
        // Frozen clock enable holds a pending trigger
        apb(1'b1, ASQ_OFF_STEP_CTL, 32'h0000_0002);
        b = u_asq_conv_model.log_q.size();
        apb(1'b1, ASQ_OFF_TRIG, 32'h1);
        clk_en <= 1'b0;
        repeat (10) @(posedge clk);
        check(u_asq_conv_model.log_q.size() - b, 0);
        clk_en <= 1'b1;
        repeat (30) @(posedge clk);
        check(u_asq_conv_model.log_q.size() - b, 1);
        apb(1'b1, ASQ_OFF_INPUT_SEL, 32'h0000_0321);
        b = u_asq_conv_model.log_q.size();
        // Every control word ends a sequence and keeps temp apart from diff
        run_seq(32'h0000_4e14, 1'b1, 3, 1'b1);
        for (int i = 0; i < 3; i++)
            check(u_asq_conv_model.log_q[b + i] & msk_t[i], exp_t[i]);
        slow <= 1'b1;
        run_seq(32'h0000_4420, 1'b0, 2, 1'b0);
        run_seq(32'h0000_0006, 1'b0, 1, 1'b1);
        slow <= 1'b0;
        run_seq(32'he000_0000, 1'b1, 8, 1'b1);
        check(u_asq_conv_model.log_q[$][15:8], 8'hf8);
        // Reset after the last sequence has finished returns the control word to zero
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, ASQ_OFF_STEP_CTL, 32'h0);
        check(rd, 32'h0);
        end_sim();
    end
endmodule
bind asq_seq0 asq_seq0_sva u_asq_seq0_sva
(
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .conv_req(conv_req)
);
